// file: testbench/tb_sleep_wake_controller.sv
`include "sleep_wake_map.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_sleep_wake_controller;
    import sleep_wake_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic sleepInstr = 1'b0, clrwdtInstr = 1'b0;
    logic [2:0] intFlagSet = 3'h0;
    logic [7:0] perFlagSet1 = 8'h00, perFlagSet2 = 8'h00, perFlagSet3 = 8'h00;
    logic extResetPin = 1'b0, brownoutDet = 1'b0, powerOnDet = 1'b0;
    logic capCharged = 1'b0, lfoscClk = 1'b0, xtalClk = 1'b0;
    logic cpuClkEn, cpuReset, prefetchNext, forceNop, vectorLoad, ioHold;
    logic lfoscRun, timerOneRun, adcRun, touchOscRun;
    logic [2:0] regPinEn;
    logic powerdownFlag, timeoutFlag;
    logic [31:0] rd;
    logic er;
    int errors = 0;
    int checked = 0;

    always #5 clk = ~clk;

    sleep_wake_controller uut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sleepInstr(sleepInstr), .clrwdtInstr(clrwdtInstr),
        .intFlagSet(intFlagSet), .perFlagSet1(perFlagSet1), .perFlagSet2(perFlagSet2),
        .perFlagSet3(perFlagSet3), .extResetPin(extResetPin), .brownoutDet(brownoutDet),
        .powerOnDet(powerOnDet), .capCharged(capCharged), .lfoscClk(lfoscClk),
        .xtalClk(xtalClk), .cpuClkEn(cpuClkEn), .cpuReset(cpuReset),
        .prefetchNext(prefetchNext), .forceNop(forceNop), .vectorLoad(vectorLoad),
        .ioHold(ioHold), .lfoscRun(lfoscRun), .timerOneRun(timerOneRun), .adcRun(adcRun),
        .touchOscRun(touchOscRun), .regPinEn(regPinEn), .powerdownFlag(powerdownFlag),
        .timeoutFlag(timeoutFlag));

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            chk(32'(pready), 32'h1);
            tally_and_finish();
        end
    endtask

    // Bounded wait on cpuReset (rstSel) or cpuClkEn
    task automatic wt(input logic rstSel, input logic v, input int lim);
        int n;
        n = 0;
        while ((rstSel ? cpuReset : cpuClkEn) !== v && n < lim) begin
            tick(1);
            n++;
        end
        if ((rstSel ? cpuReset : cpuClkEn) !== v) begin
            chk(32'(rstSel ? cpuReset : cpuClkEn), 32'(v));
            tally_and_finish();
        end
    endtask

    // drives sleepInstr high for one clock cycle
    task automatic slp();
        sleepInstr <= 1'b1;
        @(posedge clk);
        sleepInstr <= 1'b0;
        #1;
    endtask

    task automatic t_powerup();
        tick(20);
        chk(32'(cpuReset), 32'h1);
        capCharged <= 1'b1;
        wt(1'b1, 1'b0, 10);
        tick(20);
        chk(32'(cpuClkEn), 32'h1);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk({30'h0, rd[`ST_PD], rd[`ST_TO]}, 32'h3);
        chk(32'(regPinEn), 32'h0);
        $display("power-up test done");
    endtask

    task automatic t_regpin();
        for (int v = 0; v < 4; v++) begin
            apb(1'b1, `OFS_CONFIG, 32'h0F0 | v);
            apb(1'b0, `OFS_CONFIG, 32'h0);
            chk(rd, 32'h0F0 | v);
            tick(2);
            chk(32'(regPinEn), (v == 3) ? 32'h0 : (32'h1 << v));
        end
        apb(1'b0, 8'h40, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        $display("regulator pin test done");
    endtask

    task automatic t_sleep(input logic global_irq_enable, input logic [31:0] cfg, input logic run);
        apb(1'b1, `OFS_CONFIG, cfg);
        apb(1'b1, `OFS_INTCTL, global_irq_enable ? 32'h0A0 : 32'h020);
        slp();
        chk(32'(prefetchNext), 32'h1);
        chk({30'h0, cpuClkEn, ioHold}, 32'h1);
        chk({30'h0, powerdownFlag, timeoutFlag}, 32'h1);
        tick(3);
        chk({30'h0, cpuClkEn, ioHold}, 32'h1);
        chk({30'h0, lfoscRun, touchOscRun}, 32'h3);
        chk({30'h0, timerOneRun, adcRun}, {30'h0, run, run});
        intFlagSet <= 3'b100;
        @(posedge clk);
        intFlagSet <= 3'b000;
        wt(1'b0, 1'b1, 6);
        tick(1);
        chk({30'h0, vectorLoad, forceNop}, {30'h0, global_irq_enable, global_irq_enable});
        tick(1);
        chk({30'h0, vectorLoad, forceNop}, {30'h0, 1'b0, global_irq_enable});
        apb(1'b1, `OFS_INTCTL, 32'h0);
        $display("interrupt wake test done, global enable %0d", global_irq_enable);
    endtask

    task automatic t_periph();
        clrwdtInstr <= 1'b1;
        @(posedge clk);
        clrwdtInstr <= 1'b0;
        apb(1'b1, `OFS_PERIPHERAL_IRQ_FLAGS_1, 32'h0);
        apb(1'b1, `OFS_PERIPHERAL_IRQ_ENABLE_1, 32'h1);
        apb(1'b1, `OFS_INTCTL, 32'h40);
        perFlagSet1 <= 8'h01;
        @(posedge clk);
        perFlagSet1 <= 8'h00;
        tick(2);
        slp();
        tick(1);
        chk({29'h0, cpuClkEn, powerdownFlag, timeoutFlag}, 32'h7);
        apb(1'b1, `OFS_PERIPHERAL_IRQ_FLAGS_1, 32'h0);
        slp();
        perFlagSet1 <= 8'h02;
        @(posedge clk);
        perFlagSet1 <= 8'h00;
        tick(4);
        chk(32'(cpuClkEn), 32'h0);
        perFlagSet1 <= 8'h01;
        @(posedge clk);
        perFlagSet1 <= 8'h00;
        wt(1'b0, 1'b1, 6);
        chk({30'h0, powerdownFlag, timeoutFlag}, 32'h1);
        apb(1'b1, `OFS_PERIPHERAL_IRQ_FLAGS_1, 32'h0);
        apb(1'b1, `OFS_PERIPHERAL_IRQ_ENABLE_1, 32'h0);
        apb(1'b1, `OFS_INTCTL, 32'h0);
        $display("peripheral wake test done");
    endtask

    task automatic t_wdt();
        int n;
        apb(1'b1, `OFS_WDTCTL, 32'h0);
        slp();
        n = 0;
        while (cpuClkEn !== 1'b1 && n < 40) begin
            lfoscClk <= ~lfoscClk;
            tick(2);
            n++;
        end
        lfoscClk <= 1'b0;
        chk(32'(cpuClkEn), 32'h1);
        chk({29'h0, cpuReset, powerdownFlag, timeoutFlag}, 32'h0);
        apb(1'b1, `OFS_WDTCTL, 32'h16);
        $display("watchdog wake test done");
    endtask

    task automatic t_xtal();
        int n;
        apb(1'b1, `OFS_CONFIG, 32'h0F7);
        apb(1'b1, `OFS_INTCTL, 32'h020);
        slp();
        intFlagSet <= 3'b100;
        @(posedge clk);
        intFlagSet <= 3'b000;
        n = 0;
        while (cpuClkEn !== 1'b1 && n < 1200) begin
            xtalClk <= 1'b1;
            tick(1);
            xtalClk <= 1'b0;
            tick(1);
            n++;
        end
        chk(32'(n >= 1024 && n <= 1030), 32'h1);
        apb(1'b1, `OFS_INTCTL, 32'h0);
        apb(1'b1, `OFS_CONFIG, 32'h0F3);
        $display("crystal start-up test done, %0d edges", n);
    endtask

    task automatic t_reset();
        for (int k = 0; k < 3; k++) begin
            tick(2);
            slp();
            chk(32'(cpuClkEn), 32'h0);
            extResetPin <= (k == 0);
            brownoutDet <= (k == 1);
            powerOnDet <= (k == 2);
            wt(1'b1, 1'b1, 8);
            extResetPin <= 1'b0;
            brownoutDet <= 1'b0;
            powerOnDet <= 1'b0;
            wt(1'b1, 1'b0, 12);
        end
        $display("reset in sleep test done");
    endtask

    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        t_powerup();
        t_regpin();
        t_sleep(1'b1, 32'h0AF3, 1'b1);
        t_sleep(1'b0, 32'h00F3, 1'b0);
        t_periph();
        t_wdt();
        t_xtal();
        t_reset();
        tally_and_finish();
    end
endmodule // tb_sleep_wake_controller
`default_nettype wire

// file: verilog/sleep_wake_controller.sv
`include "sleep_wake_map.svh"
`timescale 1ns/1ns
`default_nettype none
module sleep_wake_controller #(
    parameter int WDT_W = 32
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleepInstr,
    input wire logic clrwdtInstr,
    input wire logic [2:0] intFlagSet,
    input wire logic [7:0] perFlagSet1,
    input wire logic [7:0] perFlagSet2,
    input wire logic [7:0] perFlagSet3,
    input wire logic extResetPin,
    input wire logic brownoutDet,
    input wire logic powerOnDet,
    input wire logic capCharged,
    input wire logic lfoscClk,
    input wire logic xtalClk,
    output logic cpuClkEn,
    output logic cpuReset,
    output logic prefetchNext,
    output logic forceNop,
    output logic vectorLoad,
    output logic ioHold,
    output logic lfoscRun,
    output logic timerOneRun,
    output logic adcRun,
    output logic touchOscRun,
    output logic [2:0] regPinEn,
    output logic powerdownFlag,
    output logic timeoutFlag
);
    import sleep_wake_pkg::*;

    pwr_state_e state_r, state_nxt;
    logic [7:0] intctl_r;
    logic [7:0] pie_r [1:3];
    logic [7:0] pir_r [1:3];
    logic [31:0] config_r;
    logic [7:0] wdtctl_r;
    logic [WDT_W-1:0] wdtCnt_r;
    logic [10:0] ostCnt_r;
    logic pd_r, to_r;
    logic [5:0] sync1_r, sync2_r;
    logic lfPrev_r, xtPrev_r;
    logic pready_r;
    logic [31:0] prdata_r;
    logic cpuClkEn_r, cpuReset_r, prefetch_r, forceNop_r, vector_r;
    logic ioHold_r, lfoscRun_r, t1Run_r, adcRun_r, csRun_r;
    logic [2:0] regPin_r;

    // Pin inputs through two flip-flops
    wire [5:0] pinIn = {xtalClk, lfoscClk, capCharged, powerOnDet, brownoutDet, extResetPin};
    always_ff @(posedge clk) begin
        sync1_r <= pinIn;
        sync2_r <= sync1_r;
    end
    wire extRst = sync2_r[0];
    wire borDet = sync2_r[1];
    wire porDet = sync2_r[2];
    wire capOk = sync2_r[3];
    always_ff @(posedge clk) begin
        lfPrev_r <= sync2_r[4];
        xtPrev_r <= sync2_r[5];
    end
    wire lfTick = sync2_r[4] & ~lfPrev_r;
    wire xtTick = sync2_r[5] & ~xtPrev_r;

    // APB decode
    wire access = psel & penable;
    wire wrEn = access & pready_r & pwrite;
    wire selIc = paddr == `OFS_INTCTL;
    wire selPie1 = paddr == `OFS_PERIPHERAL_IRQ_ENABLE_1;
    wire selPie2 = paddr == `OFS_PERIPHERAL_IRQ_ENABLE_2;
    wire selPie3 = paddr == `OFS_PERIPHERAL_IRQ_ENABLE_3;
    wire selPir1 = paddr == `OFS_PERIPHERAL_IRQ_FLAGS_1;
    wire selPir2 = paddr == `OFS_PERIPHERAL_IRQ_FLAGS_2;
    wire selPir3 = paddr == `OFS_PERIPHERAL_IRQ_FLAGS_3;
    wire selCfg = paddr == `OFS_CONFIG;
    wire selWdt = paddr == `OFS_WDTCTL;
    wire selSt = paddr == `OFS_STATUS;
    wire mapped = selIc | selPie1 | selPie2 | selPie3 | selPir1 | selPir2 | selPir3
        | selCfg | selWdt | selSt;
    wire [3:1] wrPie = {3{wrEn}} & {selPie3, selPie2, selPie1};
    wire [3:1] wrPir = {3{wrEn}} & {selPir3, selPir2, selPir1};
    wire [7:0] pMask [1:3];
    wire [7:0] pSet [1:3];
    assign pMask[1] = `MASK_P1;
    assign pMask[2] = `MASK_P2;
    assign pMask[3] = `MASK_P3;
    assign pSet[1] = perFlagSet1;
    assign pSet[2] = perFlagSet2;
    assign pSet[3] = perFlagSet3;

    // Configuration fields
    wire [1:0] vcapSel = config_r[`CFG_VCAP_LSB +: 2];
    wire crystal = config_r[`CFG_OSC_LSB +: 2] != 2'h0;
    wire [1:0] wdte = config_r[`CFG_WDTE_LSB +: 2];
    wire extRstEn = config_r[`CFG_EXTRSTE];
    wire borEn = config_r[`CFG_BORE];
    wire [2:0] t1Src = config_r[`CFG_T1SRC_LSB +: 3];
    wire adcOnRc = config_r[`CFG_ADCRC];
    wire [4:0] wdtPs = wdtctl_r[`WDT_PS_LSB +: 5];
    wire global_irq_enable = intctl_r[`IC_GIE];

    // State decode
    wire stHold = state_r == ST_HOLD;
    wire stAwake = state_r == ST_AWAKE;
    wire stSleep = state_r == ST_SLEEP;
    wire stOst = state_r == ST_OST;
    wire stResume = state_r == ST_RESUME;
    wire stFnop1 = state_r == ST_FNOP1;
    wire asleep = stSleep | stOst;

    // Wake condition needs the individual enable, not the global one
    // individual enable gating
    wire coreIrq = (intctl_r[`IC_TMR0E] & intctl_r[`IC_TMR0F])
        | (intctl_r[`IC_EXTE] & intctl_r[`IC_EXTF])
        | (intctl_r[`IC_IOCE] & intctl_r[`IC_IOCF]);
    wire perIrq = intctl_r[`IC_PERIPHERAL_IRQ_ENABLE]
        & (|((pie_r[1] & pir_r[1]) | (pie_r[2] & pir_r[2]) | (pie_r[3] & pir_r[3])));
    wire pending = coreIrq | perIrq;

    // Watchdog enable by mode and sleep state
    wire wdtActive = (wdte == WDTE_ON) | ((wdte == WDTE_AWAKE) & ~asleep)
        | ((wdte == WDTE_SW) & wdtctl_r[`WDT_SWEN]);
    wire wdtHit = wdtActive & lfTick & wdtCnt_r[wdtPs];

    wire sleepEnter = sleepInstr & stAwake & ~pending;
    wire sleepNop = sleepInstr & stAwake & pending;

    wire rstEv = porDet | (extRstEn & extRst) | (borEn & borDet) | (wdtHit & ~asleep);

    wire wakeEv = stSleep & (pending | wdtHit);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_HOLD: begin
                if (capOk & ~rstEv) begin
                    state_nxt = ST_AWAKE;
                end
            end
            ST_AWAKE: begin
                if (sleepEnter) begin
                    state_nxt = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wakeEv) begin
                    state_nxt = crystal ? ST_OST : ST_RESUME;
                end
            end
            ST_OST: begin
                if (xtTick & (ostCnt_r == `OST_COUNT - 11'h1)) begin
                    state_nxt = ST_RESUME;
                end
            end
            ST_RESUME: begin
                state_nxt = (global_irq_enable & pending) ? ST_FNOP1 : ST_AWAKE;
            end
            ST_FNOP1: begin
                state_nxt = ST_FNOP2;
            end
            ST_FNOP2: begin
                state_nxt = ST_AWAKE;
            end
            default: begin
                state_nxt = ST_HOLD;
            end
        endcase
        if (rstEv | ~capOk) begin
            state_nxt = ST_HOLD;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= ST_HOLD;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (srst | ~stOst) begin
            ostCnt_r <= 11'h0;
        end else if (xtTick) begin
            ostCnt_r <= ostCnt_r + 11'h1;
        end
    end

    // watchdog clears on entry, wake and start-up
    wire wdtClr = clrwdtInstr | sleepEnter | wakeEv | ~wdtActive | stOst | stHold;
    always_ff @(posedge clk) begin
        if (srst | wdtClr) begin
            wdtCnt_r <= '0;
        end else if (lfTick) begin
            wdtCnt_r <= wdtCnt_r + {{(WDT_W-1){1'b0}}, 1'b1};
        end
    end

    // Status flags; a no-op sleep leaves them alone
    always_ff @(posedge clk) begin
        if (srst | porDet) begin
            pd_r <= 1'b1;
            to_r <= 1'b1;
        end else if (wdtHit & stSleep) begin
            pd_r <= 1'b0;
            to_r <= 1'b0;
        end else if (wdtHit & ~asleep) begin
            pd_r <= 1'b1;
            to_r <= 1'b0;
        end else if (sleepEnter) begin
            pd_r <= 1'b0;
            to_r <= 1'b1;
        end else if (clrwdtInstr & stAwake) begin
            pd_r <= 1'b1;
            to_r <= 1'b1;
        end
    end

    // Flag registers: a hardware set wins over a software write
    always_ff @(posedge clk) begin
        if (srst) begin
            intctl_r <= 8'h00;
        end else begin
            intctl_r[7:3] <= (wrEn & selIc) ? pwdata[7:3] : intctl_r[7:3];
            intctl_r[2:0] <= ((wrEn & selIc) ? pwdata[2:0] : intctl_r[2:0]) | intFlagSet;
        end
    end

    always_ff @(posedge clk) begin
        for (int i = 1; i <= 3; i++) begin
            if (srst) begin
                pie_r[i] <= 8'h00;
                pir_r[i] <= 8'h00;
            end else begin
                if (wrPie[i]) begin
                    pie_r[i] <= pwdata[7:0] & pMask[i];
                end
                pir_r[i] <= ((wrPir[i] ? pwdata[7:0] : pir_r[i]) | pSet[i]) & pMask[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            config_r <= `CFG_RESET;
            wdtctl_r <= `WDTCTL_RESET;
        end else begin
            if (wrEn & selCfg) begin
                config_r <= {20'h0, pwdata[11:0]};
            end
            if (wrEn & selWdt) begin
                wdtctl_r <= {2'h0, pwdata[5:0]};
            end
        end
    end

    // APB read mux and one wait state
    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0;
        case (1'b1)
            selIc: rdMux = {24'h0, intctl_r};
            selPie1: rdMux = {24'h0, pie_r[1]};
            selPie2: rdMux = {24'h0, pie_r[2]};
            selPie3: rdMux = {24'h0, pie_r[3]};
            selPir1: rdMux = {24'h0, pir_r[1]};
            selPir2: rdMux = {24'h0, pir_r[2]};
            selPir3: rdMux = {24'h0, pir_r[3]};
            selCfg: rdMux = config_r;
            selWdt: rdMux = {24'h0, wdtctl_r};
            selSt: rdMux = {17'h0, state_r, 3'h0, to_r, pd_r, 3'h0};
            default: rdMux = 32'h0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready_r <= access & ~pready_r;
            prdata_r <= (access & ~pready_r & ~pwrite) ? rdMux : 32'h0;
            pslverr <= access & ~pready_r & ~mapped;
        end
    end

    // Core and clock controls, all registered; clock, reset, nop, vector and hold from the next state
    wire runNxt = (state_nxt == ST_AWAKE) | (state_nxt == ST_RESUME)
        | (state_nxt == ST_FNOP1) | (state_nxt == ST_FNOP2);
    wire sleepNxt = (state_nxt == ST_SLEEP) | (state_nxt == ST_OST);
    wire t1InSleep = (t1Src == T1_LFOSC) | (t1Src == T1_EXTPIN)
        | (t1Src == T1_OWNOSC) | (t1Src == T1_TOUCHOSC);

    always_ff @(posedge clk) begin
        if (srst) begin
            cpuClkEn_r <= 1'b0;
            cpuReset_r <= 1'b1;
            prefetch_r <= 1'b0;
            forceNop_r <= 1'b0;
            vector_r <= 1'b0;
            ioHold_r <= 1'b0;
            lfoscRun_r <= 1'b1;
            t1Run_r <= 1'b0;
            adcRun_r <= 1'b0;
            csRun_r <= 1'b1;
            regPin_r <= 3'h0;
        end else begin
            cpuClkEn_r <= runNxt;
            cpuReset_r <= state_nxt == ST_HOLD;
            prefetch_r <= sleepEnter | sleepNop;
            forceNop_r <= (state_nxt == ST_FNOP1) | (state_nxt == ST_FNOP2);
            vector_r <= state_nxt == ST_FNOP1;
            ioHold_r <= sleepNxt;
            lfoscRun_r <= 1'b1;
            // timer_one clock sources that survive sleep
            t1Run_r <= ~sleepNxt | t1InSleep;
            // ADC on RC clock and touch oscillator unaffected
            adcRun_r <= ~sleepNxt | adcOnRc;
            csRun_r <= 1'b1;
            regPin_r <= {vcapSel == 2'h2, vcapSel == 2'h1, vcapSel == 2'h0};
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign cpuClkEn = cpuClkEn_r;
    assign cpuReset = cpuReset_r;
    assign prefetchNext = prefetch_r;
    assign forceNop = forceNop_r;
    assign vectorLoad = vector_r;
    assign ioHold = ioHold_r;
    assign lfoscRun = lfoscRun_r;
    assign timerOneRun = t1Run_r;
    assign adcRun = adcRun_r;
    assign touchOscRun = csRun_r;
    assign regPinEn = regPin_r;
    assign powerdownFlag = pd_r;
    assign timeoutFlag = to_r;

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    sleep_nop_a: assert property (sleepNop && !rstEv |=> stAwake && $stable(pd_r) && $stable(to_r))
        else $error("sleep with pending interrupt changed state");
    sleep_entry_a: assert property (sleepEnter && !rstEv && capOk |=> stSleep && !pd_r && to_r && wdtCnt_r == '0)
        else $error("sleep entry status wrong");
    clock_gate_a: assert property (stSleep |-> !cpuClkEn_r && ioHold_r)
        else $error("CPU clock or pins active in sleep");
    irq_wake_a: assert property (stSleep && pending && !crystal && !rstEv && capOk |=> stResume ##1 cpuClkEn_r)
        else $error("enabled interrupt did not wake");
    ost_clear_a: assert property (stOst |=> wdtCnt_r == '0)
        else $error("watchdog counted during start-up");
    vector_nop_a: assert property (stResume && global_irq_enable && pending && !rstEv && capOk |=> stFnop1 && vectorLoad && forceNop)
        else $error("no vector after wake");
    wdt_wake_a: assert property (stSleep && wdtHit && !rstEv && capOk |=> !stHold && !to_r && !pd_r)
        else $error("watchdog in sleep reset the device");
    cap_hold_a: assert property (!capOk |=> stHold && cpuReset_r)
        else $error("reset released before capacitor charged");
    wake_clear_a: assert property (stSleep && wakeEv |=> wdtCnt_r == '0)
        else $error("watchdog not cleared on wake");
endmodule // sleep_wake_controller
`default_nettype wire

// file: verilog/sleep_wake_map.svh
`ifndef SLEEP_WAKE_MAP_SVH
`define SLEEP_WAKE_MAP_SVH

// Register byte offsets
`define OFS_INTCTL 8'h00
`define OFS_PERIPHERAL_IRQ_ENABLE_1 8'h04
`define OFS_PERIPHERAL_IRQ_ENABLE_2 8'h08
`define OFS_PERIPHERAL_IRQ_ENABLE_3 8'h0C
`define OFS_PERIPHERAL_IRQ_FLAGS_1 8'h10
`define OFS_PERIPHERAL_IRQ_FLAGS_2 8'h14
`define OFS_PERIPHERAL_IRQ_FLAGS_3 8'h18
`define OFS_CONFIG 8'h1C
`define OFS_WDTCTL 8'h20
`define OFS_STATUS 8'h24

// Interrupt control fields
`define IC_GIE 7
`define IC_PERIPHERAL_IRQ_ENABLE 6
`define IC_TMR0E 5
`define IC_EXTE 4
`define IC_IOCE 3
`define IC_TMR0F 2
`define IC_EXTF 1
`define IC_IOCF 0

// Implemented bits of the peripheral enable and flag registers
`define MASK_P1 8'hFF
`define MASK_P2 8'hFD
`define MASK_P3 8'h7A

// Configuration fields
`define CFG_VCAP_LSB 0
`define CFG_OSC_LSB 2
`define CFG_WDTE_LSB 4
`define CFG_EXTRSTE 6
`define CFG_BORE 7
`define CFG_T1SRC_LSB 8
`define CFG_ADCRC 11
`define CFG_RESET 32'h0000_00F3

// Watchdog control fields
`define WDT_SWEN 0
`define WDT_PS_LSB 1
`define WDTCTL_RESET 8'h16

// Status fields
`define ST_TO 4
`define ST_PD 3
`define ST_STATE_LSB 8

// Oscillator start-up delay in oscillator periods
`define OST_COUNT 11'h400

`endif

// file: verilog/sleep_wake_pkg.sv
package sleep_wake_pkg;

    typedef enum logic [6:0] {
        ST_HOLD = 7'h01,
        ST_AWAKE = 7'h02,
        ST_SLEEP = 7'h04,
        ST_OST = 7'h08,
        ST_RESUME = 7'h10,
        ST_FNOP1 = 7'h20,
        ST_FNOP2 = 7'h40
    } pwr_state_e;

    typedef enum logic [1:0] {
        WDTE_OFF = 2'h0,
        WDTE_SW = 2'h1,
        WDTE_AWAKE = 2'h2,
        WDTE_ON = 2'h3
    } wdt_mode_e;

    typedef enum logic [2:0] {
        T1_INSTR = 3'h0,
        T1_FOSC = 3'h1,
        T1_LFOSC = 3'h2,
        T1_EXTPIN = 3'h3,
        T1_OWNOSC = 3'h4,
        T1_TOUCHOSC = 3'h5
    } t1_src_e;

endpackage
